// ==== rtl/timer0_pkg.sv ====
// Shared constants and helper functions for the timer 0 compare/waveform block
`default_nettype none
package timer0_pkg;
	localparam int DATA_W = 32;
	localparam int PRESC_W = 10;
	localparam logic [PRESC_W-1:0] PRESC_ONE = 10'h001;
	// Register byte offsets
	localparam logic [7:0] CTRL_OFF = 8'h00;
	localparam logic [7:0] COUNT_OFF = 8'h04;
	localparam logic [7:0] COMPARE_OFF = 8'h08;
	localparam logic [7:0] FLAGS_OFF = 8'h0C;
	localparam logic [7:0] PIN_OFF = 8'h10;
	localparam logic [7:0] POWER_OFF = 8'h14;
	localparam logic [2:0] IDX_NONE = 3'h7;
	localparam logic [7:0] REG_RST = 8'h00;
	// Field positions
	localparam int WGM_LSB = 0;
	localparam int COM_LSB = 2;
	localparam int CS_LSB = 4;
	localparam int FORCE_BIT = 7;
	localparam int FLAG_OVF_BIT = 0;
	localparam int FLAG_CMP_BIT = 1;
	localparam int PIN_PORT_BIT = 0;
	localparam int PIN_DIR_BIT = 1;
	localparam int PIN_OC_BIT = 2;
	localparam int PWR_PR_BIT = 0;
	// Waveform modes, compare output modes, clock selects
	localparam logic [1:0] WGM_NORMAL = 2'h0;
	localparam logic [1:0] WGM_CTC = 2'h2;
	localparam logic [1:0] WGM_FAST = 2'h3;
	localparam logic [1:0] COM_OFF = 2'h0;
	localparam logic [1:0] COM_TOGGLE = 2'h1;
	localparam logic [1:0] COM_CLEAR = 2'h2;
	localparam logic [1:0] COM_SET = 2'h3;
	localparam logic [2:0] CS_STOP = 3'h0;
	localparam logic [2:0] CS_DIV8 = 3'h2;
	localparam logic [7:0] CNT_MAX = 8'hFF;
	localparam logic [7:0] CNT_BOTTOM = 8'h00;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam logic [1:0] RESP_DECERR = 2'h3;

	// Prescaler tap mask: tick when all masked bits are one (divide by mask+1)
	function automatic logic [PRESC_W-1:0] presc_mask(input logic [2:0] cs);
		case (cs)
			3'h2: return 10'h007;
			3'h3: return 10'h01F;
			3'h4: return 10'h03F;
			3'h5: return 10'h07F;
			3'h6: return 10'h0FF;
			3'h7: return 10'h3FF;
			default: return 10'h000;
		endcase
	endfunction

	// Compare output level after a match (or a forced match)
	function automatic logic oc_match_level(input logic [1:0] wgm, input logic [1:0] com, input logic oc);
		if (wgm == WGM_FAST)
			return (com == COM_CLEAR) ? 1'b0 : (com == COM_SET) ? 1'b1 : oc;
		case (com)
			COM_TOGGLE: return ~oc;
			COM_CLEAR: return 1'b0;
			COM_SET: return 1'b1;
			default: return oc;
		endcase
	endfunction
endpackage
`default_nettype wire

// ==== rtl/timer0_compare_waveform.sv ====
// Timer 0 counter, compare output and waveform logic with AXI4-Lite registers
`timescale 1ns/1ps
`default_nettype none
// Operation
// RULE1 - Power reduction freezes timer, refuses register access
// RULE2 - Gating works in active and idle
// RULE3 - Nonzero compare mode overrides port pin value
// RULE4 - Pin shows value only when direction output
// RULE5 - Override independent of waveform mode
// RULE6 - Compare output state presettable before enabling
// RULE7 - Compare mode zero: no action on match
// RULE8 - New compare mode acts at next match
// RULE9 - Force strobe applies action in non-PWM modes
// RULE10 - Clear-on-compare sets match flag each period
// RULE11 - No buffering: late compare wraps through 0xFF
// RULE12 - Toggle mode inverts output every match
// RULE13 - Toggle frequency is clock over 2N(1+compare)
// RULE14 - Prescaler divides by 1,8,32,64,128,256,1024
// RULE15 - Overflow flag set on max-to-zero step
// RULE16 - Mode 3 selects single-slope fast PWM
// RULE17 - Non-inverting: clear on match, set at bottom
// RULE18 - Inverting: set on match, clear at bottom
// RULE19 - Fast PWM wraps to zero after max
// RULE20 - Match flag cleared by vector or one
// RULE21 - Overflow flag cleared by vector or one
// RULE22 - Clear-on-compare resets counter after match, mode 2
module timer0_compare_waveform #(
	parameter int ADDR_W = 8
) (
	input wire logic sys_clk,
	input wire logic rstn,
	input wire logic io_clock_running,
	input wire logic compare_vector_ack,
	input wire logic overflow_vector_ack,
	output logic compare_output_pin,
	output logic compare_output_pin_oe_n,
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [timer0_pkg::DATA_W-1:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [timer0_pkg::DATA_W-1:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	import timer0_pkg::*;

	generate
		if (ADDR_W < 5 || ADDR_W > 32)
		begin : g_bad_addr
			$error("ADDR_W must lie between 5 and 32");
		end
	endgenerate

	localparam logic [2:0] IDX_CTRL = CTRL_OFF[4:2];
	localparam logic [2:0] IDX_COUNT = COUNT_OFF[4:2];
	localparam logic [2:0] IDX_COMPARE = COMPARE_OFF[4:2];
	localparam logic [2:0] IDX_FLAGS = FLAGS_OFF[4:2];
	localparam logic [2:0] IDX_PIN = PIN_OFF[4:2];
	localparam logic [2:0] IDX_POWER = POWER_OFF[4:2];

	// ****************************************************************
	// State
	// ****************************************************************
	typedef struct packed {
		logic [1:0] wgm;
		logic [1:0] com;
		logic [2:0] cs;
		logic [7:0] cnt;
		logic [7:0] ocr;
		logic cmp_f;
		logic ovf_f;
		logic port_v;
		logic dir;
		logic oc;
		logic pr;
		logic [PRESC_W-1:0] presc;
		logic aw_have;
		logic [ADDR_W-1:0] aw_addr;
		logic w_have;
		logic [7:0] w_data;
		logic w_en;
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [DATA_W-1:0] rdata;
		logic [1:0] rresp;
		logic pin_out;
		logic pin_oe_n;
	} state_t;

	// All zero except the pin enable, which is the last field and idles high
	localparam state_t STATE_RST = {{($bits(state_t) - 1){1'b0}}, 1'b1};

	state_t st_q;
	state_t st_d;

	function automatic logic [2:0] reg_index(input logic [ADDR_W-1:0] a);
		logic [ADDR_W-1:0] hi;
		hi = a >> 5;
		if (a[1:0] != 2'h0 || hi != '0 || a[4:2] > IDX_POWER)
			return IDX_NONE;
		return a[4:2];
	endfunction

	// Only the power register stays reachable while power reduction is set
	function automatic logic [1:0] access_resp(input logic [2:0] idx, input logic pr);
		if (idx == IDX_NONE)
			return RESP_DECERR;
		if (pr && idx != IDX_POWER)
			return RESP_SLVERR;
		return RESP_OKAY;
	endfunction

	logic run;
	logic tick;
	logic [PRESC_W-1:0] mask;
	logic [7:0] top;
	logic wr_go;
	logic [2:0] wr_idx;
	logic [2:0] rd_idx;
	logic [1:0] wr_resp;
	logic wr_apply;

	// ****************************************************************
	// Clock gating, prescaler and decode
	// ****************************************************************
	assign run = io_clock_running && !st_q.pr; // [RULE1] [RULE2]
	assign mask = presc_mask(st_q.cs); // [RULE14]
	assign tick = run && (st_q.cs != CS_STOP) && ((st_q.presc & mask) == mask); // [RULE13] [RULE14]
	assign top = (st_q.wgm == WGM_CTC) ? st_q.ocr : CNT_MAX; // [RULE22] [RULE19]
	assign wr_go = st_q.aw_have && st_q.w_have && !st_q.bvalid;
	assign wr_idx = reg_index(st_q.aw_addr);
	assign rd_idx = reg_index(s_axi_araddr);
	assign wr_resp = access_resp(wr_idx, st_q.pr); // [RULE1]
	assign wr_apply = wr_go && (wr_resp == RESP_OKAY) && st_q.w_en;

	// ****************************************************************
	// Next state
	// ****************************************************************
	always_comb
	begin
		logic cmp_set;
		logic cmp_clr;
		logic ovf_set;
		logic ovf_clr;
		logic [1:0] nwgm;
		logic [1:0] ncom;
		st_d = st_q;
		cmp_set = 1'b0;
		ovf_set = 1'b0;
		cmp_clr = compare_vector_ack && !st_q.pr; // [RULE20]
		ovf_clr = overflow_vector_ack && !st_q.pr; // [RULE21]
		nwgm = st_d.w_data[WGM_LSB +: 2];
		ncom = st_d.w_data[COM_LSB +: 2];
		if (run)
			st_d.presc = st_q.presc + PRESC_ONE;
		if (tick)
		begin
			// Late compare value just runs past it to MAX and wraps
			st_d.cnt = (st_q.cnt == top) ? CNT_BOTTOM : st_q.cnt + 8'h01; // [RULE11] [RULE19] [RULE22]
			ovf_set = (st_q.cnt == CNT_MAX); // [RULE15]
			if (st_q.cnt == st_q.ocr)
			begin
				cmp_set = 1'b1; // [RULE10] [RULE20]
				st_d.oc = oc_match_level(st_q.wgm, st_q.com, st_q.oc); // [RULE7] [RULE8] [RULE12] [RULE17] [RULE18]
			end
			if (st_q.wgm == WGM_FAST && st_q.cnt == CNT_MAX)
			begin
				if (st_q.com == COM_CLEAR)
					st_d.oc = 1'b1; // [RULE16] [RULE17]
				else if (st_q.com == COM_SET)
					st_d.oc = 1'b0; // [RULE18]
			end
		end
		// Write channel capture
		if (s_axi_awvalid && st_q.awready)
		begin
			st_d.aw_have = 1'b1;
			st_d.aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && st_q.wready)
		begin
			st_d.w_have = 1'b1;
			st_d.w_data = s_axi_wdata[7:0];
			st_d.w_en = s_axi_wstrb[0];
		end
		if (s_axi_bvalid && s_axi_bready)
			st_d.bvalid = 1'b0;
		if (wr_go)
		begin
			st_d.aw_have = 1'b0;
			st_d.w_have = 1'b0;
			st_d.bvalid = 1'b1;
			st_d.bresp = wr_resp;
		end
		if (wr_apply)
		begin
			case (wr_idx)
				IDX_CTRL:
				begin
					st_d.wgm = nwgm;
					st_d.com = ncom;
					st_d.cs = st_q.w_data[CS_LSB +: 3];
					// Forced match only outside the PWM modes; no flag, no clear
					if (st_q.w_data[FORCE_BIT] && !nwgm[0])
						st_d.oc = oc_match_level(nwgm, ncom, st_d.oc); // [RULE9]
				end
				IDX_COUNT: st_d.cnt = st_q.w_data;
				IDX_COMPARE: st_d.ocr = st_q.w_data; // [RULE11]
				IDX_FLAGS:
				begin
					cmp_clr = cmp_clr || st_q.w_data[FLAG_CMP_BIT]; // [RULE20]
					ovf_clr = ovf_clr || st_q.w_data[FLAG_OVF_BIT]; // [RULE21]
				end
				IDX_PIN:
				begin
					st_d.port_v = st_q.w_data[PIN_PORT_BIT];
					st_d.dir = st_q.w_data[PIN_DIR_BIT];
					st_d.oc = st_q.w_data[PIN_OC_BIT]; // [RULE6]
				end
				IDX_POWER: st_d.pr = st_q.w_data[PWR_PR_BIT]; // [RULE1]
				default: ;
			endcase
		end
		// Hardware set wins over any clear in the same cycle
		st_d.cmp_f = cmp_set || (st_q.cmp_f && !cmp_clr);
		st_d.ovf_f = ovf_set || (st_q.ovf_f && !ovf_clr);
		st_d.awready = !st_d.aw_have && !st_d.bvalid;
		st_d.wready = !st_d.w_have && !st_d.bvalid;
		// Read channel
		if (s_axi_arvalid && st_q.arready)
		begin
			st_d.rvalid = 1'b1;
			st_d.rresp = access_resp(rd_idx, st_q.pr); // [RULE1]
			st_d.rdata = '0;
			if (st_d.rresp == RESP_OKAY)
			begin
				case (rd_idx)
					IDX_CTRL:
					begin
						st_d.rdata[WGM_LSB +: 2] = st_q.wgm;
						st_d.rdata[COM_LSB +: 2] = st_q.com;
						st_d.rdata[CS_LSB +: 3] = st_q.cs;
					end
					IDX_COUNT: st_d.rdata[7:0] = st_q.cnt;
					IDX_COMPARE: st_d.rdata[7:0] = st_q.ocr;
					IDX_FLAGS:
					begin
						st_d.rdata[FLAG_CMP_BIT] = st_q.cmp_f;
						st_d.rdata[FLAG_OVF_BIT] = st_q.ovf_f;
					end
					IDX_PIN:
					begin
						st_d.rdata[PIN_PORT_BIT] = st_q.port_v;
						st_d.rdata[PIN_DIR_BIT] = st_q.dir;
						st_d.rdata[PIN_OC_BIT] = st_q.oc;
					end
					IDX_POWER: st_d.rdata[PWR_PR_BIT] = st_q.pr;
					default: ;
				endcase
			end
		end
		else if (st_q.rvalid && s_axi_rready)
			st_d.rvalid = 1'b0;
		st_d.arready = !st_d.rvalid;
		// Pin override follows the mode field in every waveform mode
		st_d.pin_out = (st_d.com != COM_OFF) ? st_d.oc : st_d.port_v; // [RULE3] [RULE5]
		st_d.pin_oe_n = !st_d.dir; // [RULE4]
	end

	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
			st_q <= STATE_RST;
		else
			st_q <= st_d;
	end

	// ****************************************************************
	// Outputs
	// ****************************************************************
	assign compare_output_pin = st_q.pin_out;
	assign compare_output_pin_oe_n = st_q.pin_oe_n;
	assign s_axi_awready = st_q.awready;
	assign s_axi_wready = st_q.wready;
	assign s_axi_bresp = st_q.bresp;
	assign s_axi_bvalid = st_q.bvalid;
	assign s_axi_arready = st_q.arready;
	assign s_axi_rdata = st_q.rdata;
	assign s_axi_rresp = st_q.rresp;
	assign s_axi_rvalid = st_q.rvalid;

	// ****************************************************************
	// Checks
	// ****************************************************************
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!rstn);

	sequence s_match_tick;
		tick && st_q.cnt == st_q.ocr && !wr_go;
	endsequence

	sequence s_fast_wrap;
		tick && st_q.wgm == WGM_FAST && st_q.cnt == CNT_MAX && !wr_go;
	endsequence

	a_gate_freeze: assert property (!run && !wr_go |=> $stable(st_q.cnt) && $stable(st_q.presc)) // [RULE1] [RULE2]
		else $error("timer state moved while clock gated");
	a_gated_refuse: assert property (wr_go && st_q.pr && wr_idx != IDX_NONE && wr_idx != IDX_POWER
		|=> s_axi_bresp == RESP_SLVERR && $stable(st_q.ocr) && $stable(st_q.cnt)) // [RULE1]
		else $error("register write accepted while gated");
	a_pin_mux: assert property (st_q.com != COM_OFF |-> compare_output_pin == st_q.oc) // [RULE3] [RULE5]
		else $error("compare output not on pin");
	a_pin_dir: assert property ($rose(st_q.dir) |-> !compare_output_pin_oe_n) // [RULE4]
		else $error("pin not driven with output direction");
	a_preset_oc: assert property (wr_apply && wr_idx == IDX_PIN |=> st_q.oc == $past(st_q.w_data[PIN_OC_BIT])) // [RULE6]
		else $error("compare output preset lost");
	a_com_zero: assert property (s_match_tick ##0 (st_q.com == COM_OFF) |=> $stable(st_q.oc)) // [RULE7] [RULE8]
		else $error("compare output changed with mode zero");
	a_force_toggle: assert property (wr_apply && wr_idx == IDX_CTRL && st_q.w_data[FORCE_BIT]
		&& st_q.w_data[WGM_LSB +: 2] == WGM_CTC && st_q.w_data[COM_LSB +: 2] == COM_TOGGLE
		&& !(tick && st_q.cnt == st_q.ocr) |=> st_q.oc != $past(st_q.oc)) // [RULE9]
		else $error("forced toggle not applied");
	a_match_flag: assert property (s_match_tick |=> st_q.cmp_f) // [RULE10] [RULE20]
		else $error("match flag not set");
	a_ctc_clear: assert property (s_match_tick ##0 (st_q.wgm == WGM_CTC) |=> st_q.cnt == CNT_BOTTOM) // [RULE22]
		else $error("counter not cleared at top");
	a_ctc_wrap: assert property (tick && !wr_go && st_q.wgm == WGM_CTC && st_q.cnt == CNT_MAX
		&& st_q.ocr != CNT_MAX |=> st_q.cnt == CNT_BOTTOM && st_q.ovf_f) // [RULE11] [RULE15]
		else $error("missed match did not wrap");
	a_ctc_toggle: assert property (s_match_tick ##0 (st_q.wgm == WGM_CTC && st_q.com == COM_TOGGLE)
		|=> st_q.oc != $past(st_q.oc)) // [RULE12]
		else $error("toggle mode did not invert");
	a_div8_tick: assert property ((tick && st_q.cs == CS_DIV8) ##1 (run && st_q.cs == CS_DIV8)[*8] |-> tick) // [RULE13] [RULE14]
		else $error("divide by 8 period wrong");
	a_fast_wrap: assert property (s_fast_wrap |=> st_q.cnt == CNT_BOTTOM && st_q.ovf_f) // [RULE16] [RULE19]
		else $error("fast PWM did not wrap");
	a_fast_noninv: assert property (s_fast_wrap ##0 (st_q.com == COM_CLEAR) |=> st_q.oc) // [RULE17]
		else $error("non-inverting output not set at bottom");
	a_fast_inv: assert property (s_match_tick ##0 (st_q.wgm == WGM_FAST && st_q.com == COM_SET
		&& st_q.cnt != CNT_MAX) |=> st_q.oc) // [RULE18]
		else $error("inverting output not set on match");
	a_ovf_clear: assert property (st_q.ovf_f && overflow_vector_ack && !st_q.pr && !tick && !wr_go
		|=> !st_q.ovf_f) // [RULE21]
		else $error("overflow flag not cleared by vector");
endmodule
`default_nettype wire

// ==== tb/pin_load.sv ====
// Load circuitry hanging on the compare output pin
`timescale 1ns/1ps
`default_nettype none
module pin_load (
	input wire logic pin,
	input wire logic oe_n,
	output logic level
);
	// A weak pull-down sets the level while the pin is not driven
	assign level = oe_n ? 1'b0 : pin;
endmodule
`default_nettype wire

// ==== tb/timer0_compare_waveform_bench.sv ====
// Self-checking bench for the timer 0 compare and waveform block
`timescale 1ns/1ps
`default_nettype none
module timer0_compare_waveform_bench;
	import timer0_pkg::*;
	logic sys_clk = 1'b0;
	logic rstn = 1'b0;
	logic io_run = 1'b1;
	logic cmp_ack = 1'b0;
	logic ovf_ack = 1'b0;
	logic pin, oe_n, lvl;
	logic [7:0] awaddr = 8'h00;
	logic [7:0] araddr = 8'h00;
	logic [31:0] wdata = 32'h00000000;
	logic [31:0] rdata;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp;
	int err_total = 0;
	int n_checks = 0;
	int cyc = 0;
	int presc [7] = '{1, 8, 32, 64, 128, 256, 1024};

	always #10 sys_clk = ~sys_clk;

	timer0_compare_waveform u_dut (
		.sys_clk(sys_clk),
		.rstn(rstn),
		.io_clock_running(io_run),
		.compare_vector_ack(cmp_ack),
		.overflow_vector_ack(ovf_ack),
		.compare_output_pin(pin),
		.compare_output_pin_oe_n(oe_n),
		.s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid),
		.s_axi_awready(awready),
		.s_axi_wdata(wdata),
		.s_axi_wstrb(4'hF),
		.s_axi_wvalid(wvalid),
		.s_axi_wready(wready),
		.s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid),
		.s_axi_bready(bready),
		.s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid),
		.s_axi_arready(arready),
		.s_axi_rdata(rdata),
		.s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid),
		.s_axi_rready(rready)
	);

	pin_load u_load (
		.pin(pin),
		.oe_n(oe_n),
		.level(lvl)
	);

	// ****************************************
	// Bus cycles and comparison helpers
	// ****************************************
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (g !== e)
		begin
			err_total++;
			$display("wrong value %s expected %0h seen %0h", nm, e, g);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er = RESP_OKAY);
		bit ad, wd;
		ad = 1'b0;
		wd = 1'b0;
		@(posedge sys_clk);
		awaddr <= a;
		wdata <= {24'h000000, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do
		begin
			@(posedge sys_clk);
			ad = ad || awready === 1'b1;
			wd = wd || wready === 1'b1;
			awvalid <= !ad;
			wvalid <= !wd;
		end while (!(ad && wd));
		do @(posedge sys_clk); while (bvalid !== 1'b1);
		bready <= 1'b0;
		chk("bresp", er, bresp);
	endtask

	task automatic rc(input logic [7:0] a, input logic [7:0] e, input logic [1:0] er = RESP_OKAY);
		@(posedge sys_clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge sys_clk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		do @(posedge sys_clk); while (rvalid !== 1'b1);
		rready <= 1'b0;
		chk("rresp", er, rresp);
		chk("rdata", {24'h000000, e}, rdata);
	endtask

	// Cycles until the pin level changes, capped at lim
	task automatic gap(output int n, input int lim = 5000);
		logic v;
		v = lvl;
		n = 0;
		do
		begin
			@(posedge sys_clk);
			n++;
		end while (lvl === v && n < lim);
	endtask

	task automatic setup(input logic [1:0] wgm, input logic [1:0] com, input logic [2:0] cs, input logic [7:0] c);
		wr(CTRL_OFF, {4'h0, com, wgm});
		wr(COMPARE_OFF, c);
		rc(COMPARE_OFF, c);
		wr(COUNT_OFF, 8'h00);
		wr(CTRL_OFF, {1'b0, cs, com, wgm});
	endtask

	task automatic pulse_ack(input bit ovf);
		@(posedge sys_clk);
		cmp_ack <= !ovf;
		ovf_ack <= ovf;
		@(posedge sys_clk);
		cmp_ack <= 1'b0;
		ovf_ack <= 1'b0;
	endtask

	task automatic end_of_test();
		$display("checks %0d mismatches %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	always @(posedge sys_clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 80000)
		begin
			err_total++;
			end_of_test();
		end
	end

	// ****************************************
	// Main sequence
	// ****************************************
	initial
	begin
		int n;
		logic [7:0] c;
		void'($urandom(32'hC77B));
		repeat (4) @(posedge sys_clk);
		rstn <= 1'b1;
		repeat (2) @(posedge sys_clk);
		for (int a = 0; a < 6; a++)
			rc(8'(a * 4), 8'h00);
		rc(8'h18, 8'h00, RESP_DECERR);
		wr(PIN_OFF, 8'h03);
		chk("pin_port", 1, {oe_n, lvl});
		wr(PIN_OFF, 8'h06);
		chk("pin_port0", 0, {oe_n, lvl});
		wr(CTRL_OFF, 8'h06);
		chk("pin_preset", 1, {oe_n, lvl});
		wr(PIN_OFF, 8'h04);
		chk("pin_input", 2, {oe_n, lvl});
		wr(PIN_OFF, 8'h06);
		wr(CTRL_OFF, 8'h86);
		rc(PIN_OFF, 8'h02);
		setup(WGM_CTC, COM_OFF, 3'h1, 8'h03);
		repeat (20) @(posedge sys_clk);
		rc(PIN_OFF, 8'h02);
		for (int i = 0; i < 7; i++)
		begin
			c = 8'($urandom_range(3));
			setup(WGM_CTC, COM_TOGGLE, 3'(i + 1), c);
			gap(n);
			gap(n);
			chk("half_period", presc[i] * (c + 1), n);
		end
		wr(CTRL_OFF, 8'h06);
		rc(FLAGS_OFF, 8'h02);
		pulse_ack(1'b0);
		rc(FLAGS_OFF, 8'h00);
		setup(WGM_CTC, COM_TOGGLE, 3'h0, 8'h05);
		wr(COUNT_OFF, 8'h10);
		wr(CTRL_OFF, 8'h16);
		gap(n);
		chk("late_match", 1, n > 240 && n < 252);
		wr(CTRL_OFF, 8'h06);
		rc(FLAGS_OFF, 8'h03);
		pulse_ack(1'b1);
		rc(FLAGS_OFF, 8'h02);
		wr(FLAGS_OFF, 8'h02);
		rc(FLAGS_OFF, 8'h00);
		// A new mode field leaves the output alone until a match
		wr(PIN_OFF, 8'h06);
		wr(CTRL_OFF, 8'h0A);
		rc(PIN_OFF, 8'h06);
		c = 8'($urandom_range(200, 10));
		for (int k = 2; k < 4; k++)
		begin
			setup(WGM_FAST, 2'(k), 3'h1, c);
			repeat (300) @(posedge sys_clk);
			n = 0;
			repeat (256)
			begin
				@(posedge sys_clk);
				n = n + int'(lvl);
			end
			chk("pwm_high", k == 2 ? c + 1 : 255 - c, n);
		end
		setup(WGM_CTC, COM_TOGGLE, 3'h1, 8'h03);
		wr(POWER_OFF, 8'h01);
		rc(COUNT_OFF, 8'h00, RESP_SLVERR);
		wr(COMPARE_OFF, 8'h55, RESP_SLVERR);
		gap(n, 40);
		chk("frozen", 40, n);
		wr(POWER_OFF, 8'h00);
		rc(COMPARE_OFF, 8'h03);
		gap(n, 100);
		gap(n, 100);
		chk("resumed", 4, n);
		@(posedge sys_clk);
		io_run <= 1'b0;
		// Let a toggle launched at the gating edge settle first
		@(posedge sys_clk);
		gap(n, 40);
		chk("idle_frozen", 40, n);
		io_run <= 1'b1;
		end_of_test();
	end
endmodule
`default_nettype wire
